// >>> rtl/mem_read_pkg.sv
// constants and types for the local memory read slave
package mem_read_pkg;
   // ****************************************************************
   // bus widths and geometry
   // ****************************************************************
   localparam int ADDR_W = 22;
   localparam int DATA_W = 16;
   localparam int BLOCK_WORDS = 16;
   localparam int FIFO_DEPTH = 16;
   localparam int MEM_WORDS = 4096;
   localparam int CNT_W = 4;
   localparam int LEFT_W = 5;

   // ****************************************************************
   // timing, in ns and in 8 ns cycles
   // ****************************************************************
   localparam int CLK_PERIOD_NS = 8;
   localparam int SEL_MAX_NS = 45;
   localparam int DATA_MAX_NS = 125;
   localparam int STB_MAX_NS = 150;
   localparam int DATA_TO_STB_MAX_NS = 75;
   localparam int SETUP_NS = 10;
   localparam int HOLD_NS = 30;
   localparam int CLEAR_MAX_NS = 50;
   localparam int REPLY_REL_MAX_NS = 100;
   // least times round up, and none below one cycle
   localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HOLD_CYC = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // longest times round down
   localparam int DATA_TO_STB_MAX_CYC = DATA_TO_STB_MAX_NS / CLK_PERIOD_NS;
   localparam int CLEAR_MAX_CYC = CLEAR_MAX_NS / CLK_PERIOD_NS;

   // ****************************************************************
   // bus side states
   // ****************************************************************
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_FIRST = 3'h1,
      ST_STROBE = 3'h2,
      ST_HOLD = 3'h3,
      ST_SECOND = 3'h4,
      ST_PAIR = 3'h5
   } bus_state_t;
endpackage : mem_read_pkg

// >>> rtl/word_fifo.sv
// synchronous word fifo with valid/ready on both sides and a flush
module word_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rstn,
   input wire logic flush,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int PW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
   logic [PW:0] cnt_r, cnt_nxt;
   logic push, pop;

   assign in_ready = (cnt_r != DEPTH[PW:0]);
   assign out_valid = (cnt_r != '0);
   assign out_data = mem[rd_r];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb begin
      wr_nxt = wr_r;
      rd_nxt = rd_r;
      cnt_nxt = cnt_r;
      if (flush) begin
         wr_nxt = '0;
         rd_nxt = '0;
         cnt_nxt = '0;
      end else begin
         if (push) wr_nxt = (wr_r == PW'(DEPTH - 1)) ? '0 : wr_r + 1'b1;
         if (pop) rd_nxt = (rd_r == PW'(DEPTH - 1)) ? '0 : rd_r + 1'b1;
         cnt_nxt = cnt_r + (PW + 1)'(push) - (PW + 1)'(pop);
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         wr_r <= '0;
         rd_r <= '0;
         cnt_r <= '0;
      end else begin
         wr_r <= wr_nxt;
         rd_r <= rd_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   always_ff @(posedge mclk) begin
      if (push && !flush) mem[wr_r] <= in_data;
   end
endmodule : word_fifo

// >>> rtl/mem_read_slave.sv
// local memory bus slave: single, paired, read-pause and block reads

// Function
// - slave asserts slave selected within 45 ns of address and page select.
// - optional reply asserted after cycle strobe, released within 100 ns.
// - reply stays disabled in systems behind the backplane bridge.
// - read data within 125 ns of cycle strobe, parity on every word while parity_enable is set.
// - read strobe negated within 150 ns of strobe, 75 ns after data.
// - data and parity held 30 ns after read strobe negation.
// - second word follows read strobe negation; bus cleared within 50 ns.
// - block mode drop removes data, restrobes; master reasserts for more pairs.
// - final pair follows block mode drop without its reassertion.
// - last word cleared within 50 ns of cycle strobe negation.
module mem_read_slave #(
   parameter int MEM_WORDS = mem_read_pkg::MEM_WORDS,
   parameter logic [20:0] BASE_WORD = 21'h000000
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // static configuration
   input wire logic reply_enable,
   input wire logic parity_enable,
   // memory preload
   input wire logic load_valid,
   input wire logic [20:0] load_addr,
   input wire logic [15:0] load_data,
   // bus inputs from the master
   input wire logic [21:0] addr_data_lines_i,
   input wire logic io_page_select,
   input wire logic byte_select_line,
   input wire logic bus_cycle_strobe,
   input wire logic block_mode_line,
   // bus outputs
   output logic [21:0] addr_data_lines_o,
   output logic addr_data_lines_oe,
   output logic high_byte_parity,
   output logic low_byte_parity,
   output logic slave_selected,
   output logic read_strobe,
   output logic reply_line_o,
   output logic reply_line_oe,
   output logic read_pause_seen
);
   localparam int AW = $clog2(MEM_WORDS);
   localparam int DW = mem_read_pkg::DATA_W;
   localparam int CW = mem_read_pkg::CNT_W;
   localparam int LW = mem_read_pkg::LEFT_W;

   // ****************************************************************
   // input synchronisers
   // ****************************************************************
   localparam int SW = 26;
   logic [SW-1:0] s1_r, s2_r;
   logic [21:0] adr_s;
   logic iop_s, byt_s, cyc_s, blk_s, blk_d_r;

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         s1_r <= '0;
         s2_r <= '0;
         blk_d_r <= 1'b0;
      end else begin
         s1_r <= {block_mode_line, bus_cycle_strobe, byte_select_line, io_page_select,
                  addr_data_lines_i};
         s2_r <= s1_r;
         blk_d_r <= blk_s;
      end
   end
   assign {blk_s, cyc_s, byt_s, iop_s, adr_s} = s2_r;

   // ****************************************************************
   // memory array and prefetch into the fifo
   // ****************************************************************
   logic [DW-1:0] ram [MEM_WORDS];
   logic [DW-1:0] ram_q_r;
   logic ram_v_r, ram_v_nxt, rd_go;
   logic [AW-1:0] fet_r, fet_nxt;
   logic [LW-1:0] left_r, left_nxt;
   logic f_in_ready, f_out_valid, f_pop, flush;
   logic [DW-1:0] f_out_data;
   logic [20:0] word_idx;
   logic hit;

   assign word_idx = adr_s[21:1] - BASE_WORD;
   assign hit = (word_idx < 21'(MEM_WORDS));
   // the ready term stalls fetching while the fifo is full, so no fetched word is lost
   assign rd_go = (left_r != '0) && f_in_ready && !ram_v_r && !flush;

   always_ff @(posedge mclk) begin
      if (load_valid) ram[load_addr[AW-1:0]] <= load_data;
      if (rd_go) ram_q_r <= ram[fet_r];
   end

   word_fifo #(
      .WIDTH(DW),
      .DEPTH(mem_read_pkg::FIFO_DEPTH)
   ) u_fifo (
      .mclk(mclk),
      .rstn(rstn),
      .flush(flush),
      .in_valid(ram_v_r),
      .in_ready(f_in_ready),
      .in_data(ram_q_r),
      .out_valid(f_out_valid),
      .out_ready(f_pop),
      .out_data(f_out_data)
   );

   // ****************************************************************
   // bus state machine
   // ****************************************************************
   mem_read_pkg::bus_state_t st_r, st_nxt;
   logic [CW-1:0] cnt_r, cnt_nxt;
   logic [DW-1:0] dat_r, dat_nxt;
   logic oe_r, oe_nxt, sel_r, sel_nxt, stb_r, stb_nxt, rep_r, rep_nxt;
   logic hp_r, hp_nxt, lp_r, lp_nxt, blk_r, blk_nxt, pause_r, pause_nxt;
   logic [3:0] off_r, off_nxt;

   always_comb begin
      st_nxt = st_r;
      cnt_nxt = cnt_r;
      dat_nxt = dat_r;
      oe_nxt = oe_r;
      sel_nxt = sel_r;
      stb_nxt = stb_r;
      hp_nxt = hp_r;
      lp_nxt = lp_r;
      blk_nxt = blk_r;
      pause_nxt = pause_r;
      off_nxt = off_r;
      fet_nxt = fet_r;
      left_nxt = left_r;
      ram_v_nxt = rd_go;
      f_pop = 1'b0;
      flush = 1'b0;
      if (rd_go) begin
         fet_nxt = fet_r + 1'b1;
         left_nxt = left_r - 1'b1;
      end
      unique case (st_r)
         mem_read_pkg::ST_IDLE: begin
            sel_nxt = iop_s && hit;
            if (sel_r && cyc_s) begin
               pause_nxt = byt_s;
               blk_nxt = 1'b0;
               fet_nxt = word_idx[AW-1:0];
               off_nxt = adr_s[4:1];
               // paired read prefetches two words, block read up to the boundary
               left_nxt = LW'(2);
               if (blk_s) begin
                  left_nxt = LW'(mem_read_pkg::BLOCK_WORDS) - {1'b0, adr_s[4:1]};
                  blk_nxt = 1'b1;
               end
               stb_nxt = 1'b1;
               st_nxt = mem_read_pkg::ST_FIRST;
            end
         end
         mem_read_pkg::ST_FIRST: begin
            if (f_out_valid) begin
               f_pop = 1'b1;
               dat_nxt = f_out_data;
               hp_nxt = parity_enable && !(^f_out_data[15:8]);
               lp_nxt = parity_enable && !(^f_out_data[7:0]);
               oe_nxt = 1'b1;
               cnt_nxt = CW'(mem_read_pkg::SETUP_CYC - 1);
               st_nxt = mem_read_pkg::ST_STROBE;
            end
         end
         mem_read_pkg::ST_STROBE: begin
            cnt_nxt = cnt_r - 1'b1;
            if (cnt_r == '0) begin
               stb_nxt = 1'b0;
               cnt_nxt = CW'(mem_read_pkg::HOLD_CYC - 1);
               st_nxt = mem_read_pkg::ST_HOLD;
            end
         end
         mem_read_pkg::ST_HOLD: begin
            cnt_nxt = cnt_r - 1'b1;
            if (cnt_r == '0) st_nxt = mem_read_pkg::ST_SECOND;
         end
         mem_read_pkg::ST_SECOND: begin
            if (f_out_valid) begin
               f_pop = 1'b1;
               dat_nxt = f_out_data;
               hp_nxt = parity_enable && !(^f_out_data[15:8]);
               lp_nxt = parity_enable && !(^f_out_data[7:0]);
               st_nxt = mem_read_pkg::ST_PAIR;
            end
         end
         mem_read_pkg::ST_PAIR: begin
            // falling block mode asks for the next pair
            if (blk_r && blk_d_r && !blk_s) begin
               oe_nxt = 1'b0;
               stb_nxt = 1'b1;
               st_nxt = mem_read_pkg::ST_FIRST;
            end
         end
         default: st_nxt = mem_read_pkg::ST_IDLE;
      endcase
      // block mode may follow the cycle strobe by a few cycles: widen the prefetch then
      if (st_r != mem_read_pkg::ST_IDLE && blk_s && !blk_r) begin
         blk_nxt = 1'b1;
         left_nxt = left_nxt + LW'(mem_read_pkg::BLOCK_WORDS - 2) - {1'b0, off_r};
      end
      // cycle strobe negation ends every transfer and clears the bus,
      // but the first word always gets its full hold time
      if (st_r != mem_read_pkg::ST_IDLE && st_r != mem_read_pkg::ST_HOLD && !cyc_s) begin
         st_nxt = mem_read_pkg::ST_IDLE;
         oe_nxt = 1'b0;
         stb_nxt = 1'b0;
         sel_nxt = 1'b0;
         hp_nxt = 1'b0;
         lp_nxt = 1'b0;
         left_nxt = '0;
         ram_v_nxt = 1'b0;
         flush = 1'b1;
      end
      rep_nxt = reply_enable && stb_nxt;
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         st_r <= mem_read_pkg::ST_IDLE;
         cnt_r <= '0;
         dat_r <= '0;
         oe_r <= 1'b0;
         sel_r <= 1'b0;
         stb_r <= 1'b0;
         rep_r <= 1'b0;
         hp_r <= 1'b0;
         lp_r <= 1'b0;
         blk_r <= 1'b0;
         pause_r <= 1'b0;
         off_r <= '0;
         fet_r <= '0;
         left_r <= '0;
         ram_v_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         dat_r <= dat_nxt;
         oe_r <= oe_nxt;
         sel_r <= sel_nxt;
         stb_r <= stb_nxt;
         rep_r <= rep_nxt;
         hp_r <= hp_nxt;
         lp_r <= lp_nxt;
         blk_r <= blk_nxt;
         pause_r <= pause_nxt;
         off_r <= off_nxt;
         fet_r <= fet_nxt;
         left_r <= left_nxt;
         ram_v_r <= ram_v_nxt;
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   assign addr_data_lines_o = {6'h00, dat_r};
   assign addr_data_lines_oe = oe_r;
   assign high_byte_parity = hp_r;
   assign low_byte_parity = lp_r;
   assign slave_selected = sel_r;
   assign read_strobe = stb_r;
   assign reply_line_o = 1'b0;
   assign reply_line_oe = rep_r;
   assign read_pause_seen = pause_r;
endmodule : mem_read_slave

// >>> tb/mem_read_slave_assertions.sv
// concurrent checks on the local memory read slave ports
module mem_read_slave_assertions #(
   parameter int MEM_WORDS = mem_read_pkg::MEM_WORDS,
   parameter logic [20:0] BASE_WORD = 21'h000000
) (
   // clock, reset and configuration
   input wire logic mclk, input wire logic rstn,
   input wire logic reply_enable, input wire logic parity_enable,
   // bus from the master
   input wire logic [21:0] addr_data_lines_i, input wire logic io_page_select,
   input wire logic bus_cycle_strobe, input wire logic block_mode_line,
   // bus from the slave
   input wire logic [21:0] addr_data_lines_o, input wire logic addr_data_lines_oe,
   input wire logic high_byte_parity, input wire logic low_byte_parity,
   input wire logic slave_selected, input wire logic read_strobe,
   input wire logic reply_line_o, input wire logic reply_line_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);
   chk_sel_timely: assert property (
      $rose(io_page_select) && addr_data_lines_i[21:1] - BASE_WORD < MEM_WORDS
      |-> ##[1:5] slave_selected) else $error("late select");
   chk_reply_off: assert property (
      !reply_enable |-> !reply_line_oe && !reply_line_o) else $error("reply driven");
   chk_reply_release: assert property (
      $fell(read_strobe) |-> ##[0:12] !reply_line_oe) else $error("reply held");
   chk_parity_match: assert property (
      addr_data_lines_oe |-> {high_byte_parity, low_byte_parity} == (parity_enable ?
      {~^addr_data_lines_o[15:8], ~^addr_data_lines_o[7:0]} : 2'h0)) else $error("bad parity");
   chk_strobe_window: assert property (
      $rose(bus_cycle_strobe) && slave_selected |-> ##[1:18] $fell(read_strobe))
      else $error("late strobe");
   chk_data_hold: assert property (
      $fell(read_strobe) |-> (addr_data_lines_oe && $stable(addr_data_lines_o))[*4])
      else $error("data not held");
   chk_bus_clear: assert property (
      $fell(bus_cycle_strobe) |-> ##[1:6] (!addr_data_lines_oe && !read_strobe))
      else $error("bus not cleared");
   chk_block_pair: assert property (
      $fell(block_mode_line) && bus_cycle_strobe && addr_data_lines_oe
      |-> ##[1:6] !addr_data_lines_oe ##[0:3] read_strobe) else $error("no next pair");
endmodule : mem_read_slave_assertions

bind mem_read_slave mem_read_slave_assertions #(.MEM_WORDS(MEM_WORDS), .BASE_WORD(BASE_WORD))
   u_mem_read_slave_assertions (.mclk, .rstn, .reply_enable, .parity_enable,
   .addr_data_lines_i, .io_page_select, .bus_cycle_strobe, .block_mode_line,
   .addr_data_lines_o, .addr_data_lines_oe, .high_byte_parity, .low_byte_parity,
   .slave_selected, .read_strobe, .reply_line_o, .reply_line_oe);

// >>> tb/bus_master_model.sv
// behavioural bus master issuing word, pause and block reads
module bus_master_model (
   // clock
   input wire logic mclk,
   // towards the slave
   output logic [21:0] addr_data_lines_i, output logic io_page_select,
   output logic byte_select_line, output logic bus_cycle_strobe, output logic block_mode_line,
   // from the slave
   input wire logic [21:0] addr_data_lines_o, input wire logic high_byte_parity,
   input wire logic low_byte_parity, input wire logic slave_selected,
   input wire logic read_strobe, input wire logic reply_line_oe,
   input wire logic read_pause_seen
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [18:0] got[$];
   logic rep_seen, sel_seen;

   initial begin
      {addr_data_lines_i, io_page_select, byte_select_line} = '0;
      {bus_cycle_strobe, block_mode_line} = 2'h0;
   end

   task automatic tick(input int n);
      repeat (n) @(negedge mclk);
   endtask : tick

   task automatic take();
      got.push_back({read_pause_seen, high_byte_parity, low_byte_parity,
         addr_data_lines_o[15:0]});
   endtask : take

   // first word is taken just after the read strobe falls; block mode comes
   // back blk_at falling edges after it was dropped, 0 for never
   task automatic strobe_word(input int blk_at);
      logic up = 1'b0;
      int n = 0;
      while (!(up && read_strobe === 1'b0) && n < 60) begin
         tick(1);
         n++;
         if (n == blk_at) block_mode_line = 1'b1;
         up = up | (read_strobe === 1'b1);
         rep_seen = rep_seen | (reply_line_oe === 1'b1);
      end
      take();
      if (blk_at > n) begin
         tick(blk_at - n);
         block_mode_line = 1'b1;
      end
   endtask : strobe_word

   task automatic bus_read(input logic [21:0] addr, input logic pause, input int words,
      input logic blk);
      int left = words;
      int again = 0;
      rep_seen = 1'b0;
      addr_data_lines_i = addr;
      io_page_select = 1'b1;
      byte_select_line = pause;
      tick(9);
      sel_seen = slave_selected;
      // no adapter on this bus: its memory hit stays negated, only a selected slave is used
      if (sel_seen === 1'b1) begin
         bus_cycle_strobe = 1'b1;
         tick(1);
         block_mode_line = blk;
         tick(5);
         // released lines show the inverse so stale values cannot pass
         addr_data_lines_i = ~addr;
         {io_page_select, byte_select_line} = 2'h0;
         while (left > 0) begin
            strobe_word(again);
            left--;
            if (left > 0) begin
               tick(12);
               take();
               left--;
            end
            again = 0;
            if (left > 0) begin
               block_mode_line = 1'b0;
               if (left >= 4) again = 6;
            end
         end
      end
      {bus_cycle_strobe, block_mode_line, io_page_select, byte_select_line} = 4'h0;
      tick(8);
   endtask : bus_read
endmodule : bus_master_model

// >>> tb/tb_local_memory_bus_read_cycles.sv
// self-checking bench for the local memory read slave
module tb_local_memory_bus_read_cycles;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {logic [21:0] addr; logic pause; int words; logic blk;} row_t;
   logic mclk, rstn, reply_enable, parity_enable, load_valid;
   logic [20:0] load_addr;
   logic [15:0] load_data;
   logic [21:0] addr_data_lines_i, addr_data_lines_o;
   logic io_page_select, byte_select_line, bus_cycle_strobe, block_mode_line;
   logic addr_data_lines_oe, high_byte_parity, low_byte_parity, slave_selected;
   logic read_strobe, reply_line_o, reply_line_oe, read_pause_seen;
   int err_total = 0;
   int n_tests = 0;
   // address, pause, words back, block; blocks start even and stop at the boundary
   row_t rows[7] = '{'{22'h000100, 1'b0, 1, 1'b0}, '{22'h000102, 1'b0, 2, 1'b0},
      '{22'h000104, 1'b1, 2, 1'b0}, '{22'h000040, 1'b0, 16, 1'b1},
      '{22'h000058, 1'b0, 4, 1'b1}, '{22'h00007C, 1'b0, 2, 1'b1},
      '{22'h001FFE, 1'b0, 1, 1'b0}};

   mem_read_slave u_mem_read_slave (.mclk, .rstn, .reply_enable, .parity_enable,
      .load_valid, .load_addr, .load_data, .addr_data_lines_i, .io_page_select,
      .byte_select_line, .bus_cycle_strobe, .block_mode_line, .addr_data_lines_o,
      .addr_data_lines_oe, .high_byte_parity, .low_byte_parity, .slave_selected,
      .read_strobe, .reply_line_o, .reply_line_oe, .read_pause_seen);
   bus_master_model u_bus_master_model (.mclk, .addr_data_lines_i, .io_page_select,
      .byte_select_line, .bus_cycle_strobe, .block_mode_line, .addr_data_lines_o,
      .high_byte_parity, .low_byte_parity, .slave_selected, .read_strobe,
      .reply_line_oe, .read_pause_seen);

   function automatic logic [15:0] word_of(input logic [20:0] w);
      return {w[7:0], ~w[7:0]};
   endfunction : word_of

   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      n_tests++;
      if (seen !== want) begin
         err_total++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, want);
      end
   endtask : check

   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : complete_run

   task automatic run(input row_t r);
      logic [20:0] w;
      logic [18:0] g;
      logic [15:0] d;
      w = r.addr[21:1];
      u_bus_master_model.bus_read(r.addr, r.pause, r.words, r.blk);
      check(u_bus_master_model.rep_seen, reply_enable);
      while (u_bus_master_model.got.size() > 0) begin
         g = u_bus_master_model.got.pop_front();
         d = word_of(w);
         check(g[15:0], d);
         check(g[17:16], parity_enable ? {~^d[15:8], ~^d[7:0]} : 2'h0);
         check(g[18], r.pause);
         w++;
      end
      $display("read at %h of %0d words done", r.addr, r.words);
   endtask : run

   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   initial begin
      repeat (20000) @(posedge mclk);
      err_total++;
      $display("[ERR] %0t run did not finish", $time);
      complete_run();
   end

   initial begin
      {rstn, load_valid, load_addr, load_data} = '0;
      {reply_enable, parity_enable} = 2'h3;
      repeat (8) @(negedge mclk);
      rstn = 1'b1;
      repeat (3) @(negedge mclk);
      load_valid = 1'b1;
      for (int i = 0; i < 257; i++) begin
         load_addr = (i == 256) ? 21'h000FFF : 21'(i);
         load_data = word_of(load_addr);
         @(negedge mclk);
      end
      load_valid = 1'b0;
      foreach (rows[i]) run(rows[i]);
      // pause read with reply and parity switched off
      {reply_enable, parity_enable} = 2'h0;
      run(rows[2]);
      {reply_enable, parity_enable} = 2'h3;
      // first word beyond the memory gets no answer
      u_bus_master_model.bus_read(22'h002000, 1'b0, 1, 1'b0);
      check(u_bus_master_model.sel_seen, 1'b0);
      $display("out of range read done");
      // reset in the middle of a read drops data enable, read strobe, slave selected and reply
      fork
         u_bus_master_model.bus_read(22'h000100, 1'b0, 1, 1'b0);
         begin
            repeat (14) @(negedge mclk);
            rstn = 1'b0;
            @(negedge mclk);
            check({addr_data_lines_oe, read_strobe, slave_selected, reply_line_oe}, 4'h0);
            rstn = 1'b1;
         end
      join
      u_bus_master_model.got.delete();
      $display("reset in mid read done");
      complete_run();
   end
endmodule : tb_local_memory_bus_read_cycles
